// ### rff_pkg.sv
package rff_pkg;

  localparam int NUM_FILTERS = 31;
  localparam int ADDR_W = 16;

  // Register group bases; filter n sits at base + 8*n
  localparam logic [15:0] HDR_FLAGS_BASE = 16'h3500;
  localparam logic [15:0] TCP_MASK_BASE = 16'h3600;
  localparam logic [15:0] ADDR_WORD1_BASE = 16'h3700;
  localparam logic [15:0] ADDR_WORD2_BASE = 16'h3800;
  localparam logic [15:0] ADDR_WORD3_BASE = 16'h3900;
  localparam logic [15:0] CLASS_CTRL_BASE = 16'h3A00;
  localparam logic [15:0] ADDR_WORD0_BASE = 16'h3B00;
  localparam logic [15:0] FILTER_STRIDE = 16'h0008;

  // Field positions
  localparam int HDR_FLAGS_MSB = 7;
  localparam int FLAGS_MSB = 5;
  localparam int FIN_BIT = 0;
  localparam int SYN_BIT = 1;
  localparam int RST_BIT = 2;
  localparam int PSH_BIT = 3;
  localparam int ACK_BIT = 4;
  localparam int URG_BIT = 5;
  localparam int CLASS_MSB = 1;
  localparam int IPV6_SEL_BIT = 30;

  // Reset values
  localparam logic [7:0] HDR_FLAGS_RESET = 8'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] CLASS_RESET = 2'h0;

  typedef enum logic [1:0] {
    CLASS_TCP = 2'b00,
    CLASS_UDP = 2'b01,
    CLASS_IP_OTHER = 2'b10,
    CLASS_NON_IP = 2'b11
  } rff_class_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } rff_avm_req_s;

  // addr[127:120] is the first address byte on the wire
  typedef struct packed {
    logic valid;
    logic [7:0] next_header;
    logic [5:0] tcp_flags;
    logic [127:0] addr;
  } rff_pkt_s;

  typedef struct packed {
    logic hit;
    logic [15:0] base;
    logic [4:0] idx;
  } rff_dec_s;

endpackage

// ### rff_filter.sv
`timescale 1ns/1ps
// Overview of operation
// - IP/other class: compare byte is the expected next-header value.
// - TCP class compares low six bits to TCP flags; UDP and non-IP classes ignore it.
// - Flag bits: 0 FIN,1 SYN,2 RST,3 PSH,4 ACK,5 URG; bits 7:6 reserved.
// - TCP class: mask bit 0 enables FIN comparison, clear ignores FIN.
// - IP/other class: mask bit 0 enables next-header compare, else address only.
// - Mask bits 5:1 enable matching flag compares, TCP class only.
// - Address words 1..3 give IPv6 bits 63:32,95:64,127:96; used if IPv6 selected and class is not non-IP.
// - Top byte of word 3 meets first wire byte; low byte of word 0 last.
// - 31 copies per register, filter n at group base plus 8*n.
// - Reset clears compare byte, mask and address words; reserved bits read-only.
// - Class encoding: 00/01 TCP or UDP, 10 IP other, 11 non-IP.
// - Bit 30 of the class control register selects IPv6 address match.
module rff_filter #(
  parameter int NF = rff_pkg::NUM_FILTERS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire rff_pkg::rff_avm_req_s avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire rff_pkg::rff_pkt_s pkt_in,
  output logic [NF-1:0] match_vec,
  output logic match_valid
);
  import rff_pkg::*;

  logic [7:0] hdr_flags [NF];
  logic [5:0] fmask [NF];
  logic [31:0] word0 [NF];
  logic [31:0] word1 [NF];
  logic [31:0] word2 [NF];
  logic [31:0] word3 [NF];
  logic [1:0] pclass [NF];
  logic [NF-1:0] ipv6_sel;

  logic [7:0] next_hdr_flags [NF];
  logic [5:0] next_fmask [NF];
  logic [31:0] next_word0 [NF];
  logic [31:0] next_word1 [NF];
  logic [31:0] next_word2 [NF];
  logic [31:0] next_word3 [NF];
  logic [1:0] next_pclass [NF];
  logic [NF-1:0] next_ipv6_sel;

  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [NF-1:0] next_match_vec;
  logic next_match_valid;

  rff_dec_s dec;
  logic req;
  logic accept;

  function automatic rff_dec_s decode(input logic [15:0] a);
    rff_dec_s d;
    d.base = {a[15:8], 8'h00};
    d.idx = a[7:3];
    d.hit = (a[2:0] == 3'h0) && (int'(a[7:3]) < NF) &&
            (d.base >= HDR_FLAGS_BASE) && (d.base <= ADDR_WORD0_BASE);
    return d;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign dec = decode(avm_req.address);
  assign req = avm_req.read | avm_req.write;
  // A request completes at the edge where waitrequest is seen low
  assign accept = req & ~avm_waitrequest;

  always_comb begin
    next_waitrequest = 1'b1;
    if (req && avm_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    next_readdata = 32'h0000_0000;
    if (avm_req.read && dec.hit) begin
      case (dec.base)
        HDR_FLAGS_BASE: next_readdata = {24'h000000, hdr_flags[dec.idx]};
        TCP_MASK_BASE: next_readdata = {26'h0000000, fmask[dec.idx]};
        ADDR_WORD1_BASE: next_readdata = word1[dec.idx];
        ADDR_WORD2_BASE: next_readdata = word2[dec.idx];
        ADDR_WORD3_BASE: next_readdata = word3[dec.idx];
        ADDR_WORD0_BASE: next_readdata = word0[dec.idx];
        CLASS_CTRL_BASE: begin
          next_readdata = 32'h0000_0000;
          next_readdata[CLASS_MSB:0] = pclass[dec.idx];
          next_readdata[IPV6_SEL_BIT] = ipv6_sel[dec.idx];
        end
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_hdr_flags = hdr_flags;
    next_fmask = fmask;
    next_word0 = word0;
    next_word1 = word1;
    next_word2 = word2;
    next_word3 = word3;
    next_pclass = pclass;
    next_ipv6_sel = ipv6_sel;
    if (accept && avm_req.write && dec.hit) begin
      case (dec.base)
        HDR_FLAGS_BASE: begin
          // Upper bits are not stored, so they stay read-only zero
          if (avm_req.byteenable[0]) begin
            next_hdr_flags[dec.idx] = avm_req.writedata[HDR_FLAGS_MSB:0];
          end
        end
        TCP_MASK_BASE: begin
          if (avm_req.byteenable[0]) begin
            next_fmask[dec.idx] = avm_req.writedata[FLAGS_MSB:0];
          end
        end
        ADDR_WORD1_BASE: begin
          next_word1[dec.idx] = merge(word1[dec.idx], avm_req.writedata, avm_req.byteenable);
        end
        ADDR_WORD2_BASE: begin
          next_word2[dec.idx] = merge(word2[dec.idx], avm_req.writedata, avm_req.byteenable);
        end
        ADDR_WORD3_BASE: begin
          next_word3[dec.idx] = merge(word3[dec.idx], avm_req.writedata, avm_req.byteenable);
        end
        ADDR_WORD0_BASE: begin
          next_word0[dec.idx] = merge(word0[dec.idx], avm_req.writedata, avm_req.byteenable);
        end
        CLASS_CTRL_BASE: begin
          if (avm_req.byteenable[0]) begin
            next_pclass[dec.idx] = avm_req.writedata[CLASS_MSB:0];
          end
          if (avm_req.byteenable[3]) begin
            next_ipv6_sel[dec.idx] = avm_req.writedata[IPV6_SEL_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    logic [5:0] en;
    logic proto_ok;
    logic addr_ok;
    en = 6'h00;
    proto_ok = 1'b1;
    addr_ok = 1'b1;
    next_match_vec = '0;
    next_match_valid = pkt_in.valid;
    for (int n = 0; n < NF; n++) begin
      proto_ok = 1'b1;
      addr_ok = 1'b1;
      en = 6'h00;
      case (rff_class_e'(pclass[n]))
        CLASS_TCP: begin
          // Mask bit 0 gates FIN, bits 5:1 gate SYN..URG
          en[FIN_BIT] = fmask[n][FIN_BIT];
          en[URG_BIT:SYN_BIT] = fmask[n][URG_BIT:SYN_BIT];
          proto_ok = ((pkt_in.tcp_flags ^ hdr_flags[n][FLAGS_MSB:0]) & en) ==
                     6'h00;
        end
        CLASS_IP_OTHER: begin
          if (fmask[n][FIN_BIT]) begin
            proto_ok = (pkt_in.next_header == hdr_flags[n]);
          end
        end
        default: proto_ok = 1'b1;
      endcase
      // No IPv4 address compare or masking; addr_ok stays 1 unless IPv6 is selected
      if (ipv6_sel[n] && (rff_class_e'(pclass[n]) != CLASS_NON_IP)) begin
        addr_ok = (pkt_in.addr == {word3[n], word2[n], word1[n], word0[n]});
      end
      next_match_vec[n] = pkt_in.valid & proto_ok & addr_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int n = 0; n < NF; n++) begin
        hdr_flags[n] <= HDR_FLAGS_RESET;
        fmask[n] <= MASK_RESET;
        word0[n] <= WORD_RESET;
        word1[n] <= WORD_RESET;
        word2[n] <= WORD_RESET;
        word3[n] <= WORD_RESET;
        pclass[n] <= CLASS_RESET;
      end
      ipv6_sel <= '0;
    end else begin
      hdr_flags <= next_hdr_flags;
      fmask <= next_fmask;
      word0 <= next_word0;
      word1 <= next_word1;
      word2 <= next_word2;
      word3 <= next_word3;
      pclass <= next_pclass;
      ipv6_sel <= next_ipv6_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      avm_readdata <= 32'h0000_0000;
      avm_waitrequest <= 1'b1;
      match_vec <= '0;
      match_valid <= 1'b0;
    end else begin
      avm_readdata <= next_readdata;
      avm_waitrequest <= next_waitrequest;
      match_vec <= next_match_vec;
      match_valid <= next_match_valid;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_hdr_flags_write(int n);
    accept && avm_req.write && dec.hit && dec.base == HDR_FLAGS_BASE &&
      int'(dec.idx) == n && avm_req.byteenable[0];
  endsequence

  a_cmp_write_store: assert property (
    s_hdr_flags_write(0) |=> hdr_flags[0] == $past(avm_req.writedata[7:0]))
    else $error("compare byte not stored");

  a_stride_filter_one: assert property (
    s_hdr_flags_write(1) |=> hdr_flags[1] == $past(avm_req.writedata[7:0]) &&
      $stable(hdr_flags[0]))
    else $error("stride decode wrong");

  a_cmp_reserved_zero: assert property (
    accept && avm_req.read && dec.hit && dec.base == HDR_FLAGS_BASE |->
      avm_readdata[31:8] == 24'h000000)
    else $error("reserved bits not zero");

  a_mask_reserved_zero: assert property (
    accept && avm_req.read && dec.hit && dec.base == TCP_MASK_BASE |->
      avm_readdata[31:6] == 26'h0)
    else $error("mask reserved bits not zero");

  a_reset_clears_regs: assert property (disable iff (1'b0)
    !nrst |=> hdr_flags[0] == 8'h00 && fmask[0] == 6'h00 && word3[0] == 32'h0000_0000)
    else $error("reset did not clear");

  a_tcp_flag_miss: assert property (
    pkt_in.valid && pclass[2] == CLASS_TCP &&
      ((pkt_in.tcp_flags ^ hdr_flags[2][5:0]) & fmask[2]) != 6'h00 |=> !match_vec[2])
    else $error("tcp flag mismatch matched");

  a_fin_ignored: assert property (
    pkt_in.valid && pclass[2] == CLASS_TCP && !ipv6_sel[2] && !fmask[2][0] &&
      ((pkt_in.tcp_flags ^ hdr_flags[2][5:0]) & fmask[2]) == 6'h00 |=> match_vec[2])
    else $error("unmasked fin affected match");

  a_next_header_miss: assert property (
    pkt_in.valid && pclass[1] == CLASS_IP_OTHER && fmask[1][0] &&
      pkt_in.next_header != hdr_flags[1] |=> !match_vec[1])
    else $error("next header mismatch matched");

  a_udp_ignores_byte: assert property (
    pkt_in.valid && pclass[4] == CLASS_UDP && !ipv6_sel[4] |=> match_vec[4] ##1 1'b1)
    else $error("udp filter compared byte");

  a_non_ip_passes: assert property (
    pkt_in.valid && pclass[5] == CLASS_NON_IP |=> match_vec[5])
    else $error("non-IP filter compared fields");

  a_ipv6_addr_miss: assert property (
    pkt_in.valid && ipv6_sel[3] && pclass[3] != CLASS_NON_IP &&
      pkt_in.addr[127:120] != word3[3][31:24] |=> !match_vec[3])
    else $error("ipv6 first byte mismatch matched");

  a_low_word_miss: assert property (
    pkt_in.valid && ipv6_sel[3] && pclass[3] != CLASS_NON_IP &&
      pkt_in.addr[63:32] != word1[3] |=> !match_vec[3])
    else $error("ipv6 word1 mismatch matched");

  a_match_valid_pulse: assert property (
    pkt_in.valid |=> match_valid)
    else $error("match valid missing");

  a_idle_vec_zero: assert property (
    !pkt_in.valid |=> !match_valid && match_vec == '0)
    else $error("match outputs not idle");

  a_wait_one_cycle: assert property (
    req && avm_waitrequest |=> !avm_waitrequest ##1 avm_waitrequest)
    else $error("waitrequest not a single low cycle");

endmodule

// ### rff_pkt_src.sv
`timescale 1ns/1ps
module rff_pkt_src (
  input wire logic ref_clk,
  output rff_pkg::rff_pkt_s pkt_out
);
  import rff_pkg::*;

  initial begin
    pkt_out = '0;
  end

  // Stale fields are inverted once valid drops, so a design that ignores valid is caught
  task automatic send(input logic [7:0] nh, input logic [5:0] fl, input logic [127:0] ad);
    @(posedge ref_clk);
    pkt_out <= '{valid: 1'b1, next_header: nh, tcp_flags: fl, addr: ad};
    @(posedge ref_clk);
    pkt_out <= '{valid: 1'b0, next_header: ~nh, tcp_flags: ~fl, addr: ~ad};
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rff_pkg::*;
  logic ref_clk;
  logic nrst;
  rff_avm_req_s avm_req;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  rff_pkt_s pkt_in;
  logic [NUM_FILTERS-1:0] match_vec;
  logic match_valid;
  int n_mismatch;
  int cmp_count;
  int cycles;
  logic [31:0] rdata;
  logic [127:0] v6;
  logic [15:0] bases [7];

  rff_filter i_rff_filter (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .avm_req(avm_req),
    .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest),
    .pkt_in(pkt_in),
    .match_vec(match_vec),
    .match_valid(match_valid)
  );

  rff_pkt_src i_rff_pkt_src (
    .ref_clk(ref_clk),
    .pkt_out(pkt_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [15:0] ra(input logic [15:0] base, input int n);
    return base + FILTER_STRIDE * 16'(n);
  endfunction

  // Request stands until an edge samples waitrequest low; only the bench timeout ends a hang
  task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    avm_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: 4'hF};
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (avm_waitrequest !== 1'b0);
    rdata = avm_readdata;
    chk("wait_edges", k, 32'h2);
    avm_req <= '0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input string name);
    bus(1'b1, a, 32'h0);
    chk(name, rdata, exp);
  endtask

  task automatic pkt(input logic [7:0] nh, input logic [5:0] fl, input logic [127:0] ad,
                     input int n, input logic exp);
    i_rff_pkt_src.send(nh, fl, ad);
    // Results stand for the one cycle after the edge that took the packet
    @(negedge ref_clk);
    chk("match_valid", {31'h0, match_valid}, 32'h1);
    chk("match_bit", {31'h0, match_vec[n]}, {31'h0, exp});
    @(negedge ref_clk);
    chk("idle_vec", {match_vec, match_valid}, 32'h0);
  endtask

  initial begin
    nrst = 1'b0;
    avm_req = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    v6 = 128'h0123_4567_89AB_CDEF_0246_8ACE_1357_9BDF;
    bases = '{HDR_FLAGS_BASE, TCP_MASK_BASE, ADDR_WORD1_BASE, ADDR_WORD2_BASE,
              ADDR_WORD3_BASE, CLASS_CTRL_BASE, ADDR_WORD0_BASE};
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int g = 0; g < 7; g++) begin
      rdchk(ra(bases[g], 0), 32'h0, "reset_first");
      rdchk(ra(bases[g], 30), 32'h0, "reset_last");
    end
    // Filter 5 ends up non-IP with every field but address word 0 set; it must still pass
    for (int g = 0; g < 6; g++) begin
      wr(ra(bases[g], 5), 32'hFFFF_FFFF);
    end
    rdchk(ra(HDR_FLAGS_BASE, 5), 32'h0000_00FF, "cmp_reserved");
    rdchk(ra(TCP_MASK_BASE, 5), 32'h0000_003F, "mask_reserved");
    rdchk(ra(CLASS_CTRL_BASE, 5), 32'h4000_0003, "class_bits");
    rdchk(ra(ADDR_WORD3_BASE, 5), 32'hFFFF_FFFF, "word3_rw");
    for (int n = 0; n < NUM_FILTERS; n++) begin
      wr(ra(ADDR_WORD1_BASE, n), 32'hA500_0000 | n);
    end
    for (int n = 0; n < NUM_FILTERS; n++) begin
      rdchk(ra(ADDR_WORD1_BASE, n), 32'hA500_0000 | n, "stride");
    end
    wr(ra(HDR_FLAGS_BASE, 31), 32'h0000_00AA);
    rdchk(ra(HDR_FLAGS_BASE, 31), 32'h0, "index31");
    wr(HDR_FLAGS_BASE + 16'h0004, 32'h0000_00AA);
    rdchk(HDR_FLAGS_BASE + 16'h0004, 32'h0, "misaligned");
    rdchk(ra(HDR_FLAGS_BASE, 0), 32'h0, "no_alias");
    pkt(8'h00, 6'h00, 128'h0, 5, 1'b1);
    wr(ra(CLASS_CTRL_BASE, 1), 32'h0000_0002);
    wr(ra(HDR_FLAGS_BASE, 1), 32'h0000_0011);
    wr(ra(TCP_MASK_BASE, 1), 32'h0000_0001);
    pkt(8'h11, 6'h3F, 128'h0, 1, 1'b1);
    pkt(8'h06, 6'h11, 128'h0, 1, 1'b0);
    wr(ra(TCP_MASK_BASE, 1), 32'h0000_0000);
    pkt(8'h06, 6'h00, 128'h0, 1, 1'b1);
    // Walk each flag position alone in filter 2 (TCP class from reset)
    for (int b = 0; b < 6; b++) begin
      wr(ra(HDR_FLAGS_BASE, 2), 32'h1 << b);
      wr(ra(TCP_MASK_BASE, 2), 32'h1 << b);
      pkt(8'hFF, 6'h1 << b, 128'h0, 2, 1'b1);
      pkt(8'h00, ~(6'h1 << b), 128'h0, 2, 1'b0);
    end
    wr(ra(HDR_FLAGS_BASE, 2), 32'h0000_0012);
    wr(ra(TCP_MASK_BASE, 2), 32'h0000_0012);
    pkt(8'h00, 6'h33, 128'h0, 2, 1'b1);
    pkt(8'h12, 6'h10, 128'h0, 2, 1'b0);
    wr(ra(CLASS_CTRL_BASE, 4), 32'h0000_0001);
    wr(ra(HDR_FLAGS_BASE, 4), 32'h0000_00FF);
    wr(ra(TCP_MASK_BASE, 4), 32'h0000_003F);
    pkt(8'h00, 6'h00, 128'h0, 4, 1'b1);
    wr(ra(CLASS_CTRL_BASE, 3), 32'h4000_0002);
    wr(ra(ADDR_WORD3_BASE, 3), v6[127:96]);
    wr(ra(ADDR_WORD2_BASE, 3), v6[95:64]);
    wr(ra(ADDR_WORD1_BASE, 3), v6[63:32]);
    wr(ra(ADDR_WORD0_BASE, 3), v6[31:0]);
    pkt(8'h00, 6'h00, v6, 3, 1'b1);
    pkt(8'h00, 6'h00, v6 ^ {8'h01, 120'h0}, 3, 1'b0);
    pkt(8'h00, 6'h00, v6 ^ (128'h1 << 32), 3, 1'b0);
    pkt(8'h00, 6'h00, v6 ^ (128'h1 << 32), 6, 1'b1);
    wr(ra(HDR_FLAGS_BASE, 0), 32'h0000_005A);
    rdchk(ra(HDR_FLAGS_BASE, 0), 32'h0000_005A, "filter0_byte");
    conclude();
  end
endmodule
